// >>> core/uxcr_pkg.sv
/*
 package for the extended configuration register bank of one uart channel:
 register offsets, unlock values, reset values and field layouts.
 assumes nothing of its surroundings.
*/
package uxcr_pkg;

   // register offsets on the 5-bit register port
   localparam logic [4:0] ADR_PRESC = 5'h04;
   localparam logic [4:0] ADR_CNT   = 5'h05;
   localparam logic [4:0] ADR_TFL   = 5'h06;
   localparam logic [4:0] ADR_SFC   = 5'h07;
   localparam logic [4:0] ADR_IDLE  = 5'h08;
   localparam logic [4:0] ADR_TRC   = 5'h09;
   localparam logic [4:0] ADR_KEY   = 5'h0d;
   localparam logic [4:0] ADR_TRX   = 5'h10;

   // unlock values
   localparam logic [7:0] LINE_CTL_UNLOCK = 8'hbf;
   localparam logic [7:0] KEY_VALUE       = 8'h5a;

   // reset values
   localparam logic [7:0] SFC_RST   = 8'h00;
   localparam logic [7:0] IDLE_RST  = 8'h00;
   localparam logic [7:0] TRC_RST   = 8'h06;
   localparam logic [7:0] PRESC_RST = 8'h10;
   localparam logic [7:0] KEY_RST   = 8'h00;
   localparam logic [7:0] TRX_RST   = 8'h00;

   // baud oversample base
   localparam logic [6:0] SAMPLE_BASE = 7'h10;

   // special function control layout, bit 7 first
   typedef struct packed {
      logic xtal_fb_dis;
      logic cnt_sel;
      logic rsvd;
      logic burst;
      logic loopback;
      logic spec_access;
      logic auto_dsr_dtr;
      logic force_tx;
   } uxcr_sfc_t;

   // tx/rx control layout
   typedef struct packed {
      logic [4:0] sample_clk;
      logic       xon_inband;
      logic       tx_empty_ie;
      logic       rx_timeout_en;
   } uxcr_trc_t;

   // clock prescale layout
   typedef struct packed {
      logic [3:0] m_factor;
      logic [3:0] n_factor;
   } uxcr_presc_t;

   // own extension: idle insertion enable in bit 0
   typedef struct packed {
      logic [6:0] rsvd;
      logic       idle_ins_en;
   } uxcr_trx_t;

endpackage

// >>> core/uxcr_baud_gen.sv
/*
 baud tick generator: input clock divided by
 divisor * 2^(m + 2*modem7 - 1) * (16 - sample + n), as three cascaded counters.
 assumes settings from same-clock registers.
*/
`timescale 1ns/1ps
module uxcr_baud_gen (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // settings
   input  wire logic [15:0] i_divisor,
   input  wire logic        i_modem7,
   input  wire logic [3:0]  i_m_factor,
   input  wire logic [3:0]  i_n_factor,
   input  wire logic [4:0]  i_sample_clk,
   // tick
   output logic             o_baud_tick
);
   logic [5:0]  exp_raw;
   logic [4:0]  exp_eff;
   logic [16:0] pre_len;
   logic [6:0]  smp_raw;
   logic [6:0]  smp_len;
   logic [15:0] div_len;
   logic [16:0] pre_q;
   logic [15:0] div_q;
   logic [6:0]  smp_q;
   logic        pre_tick;
   logic        div_tick;

   always_comb begin
      exp_raw = {2'h0, i_m_factor} + (i_modem7 ? 6'h02 : 6'h00);
      exp_eff = (exp_raw == 6'h00) ? 5'h00 : 5'(exp_raw - 6'h01);
      pre_len = 17'h00001 << exp_eff;
      smp_raw = uxcr_pkg::SAMPLE_BASE + {3'h0, i_n_factor} - {2'h0, i_sample_clk};
      smp_len = (smp_raw[6] || smp_raw == 7'h00) ? 7'h01 : smp_raw;
      div_len = (i_divisor == 16'h0000) ? 16'h0001 : i_divisor;
   end

   assign pre_tick = (pre_q >= pre_len - 17'h00001);
   assign div_tick = pre_tick && (div_q >= div_len - 16'h0001);

   // counter chain
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_q       <= '0;
         div_q       <= '0;
         smp_q       <= '0;
         o_baud_tick <= 1'b0;
      end else begin
         pre_q       <= pre_tick ? 17'h00000 : pre_q + 17'h00001;
         if (pre_tick) begin
            div_q <= div_tick ? 16'h0000 : div_q + 16'h0001;
         end
         o_baud_tick <= 1'b0;
         if (div_tick) begin
            if (smp_q >= smp_len - 7'h01) begin
               smp_q       <= 7'h00;
               o_baud_tick <= 1'b1;
            end else begin
               smp_q <= smp_q + 7'h01;
            end
         end
      end
   end
endmodule // uxcr_baud_gen

// >>> core/uxcr_idle_ins.sv
/*
 idle time inserter: after each sent character holds the transmitter
 for the programmed number of baud ticks.
 assumes char-done and baud tick are same-clock pulses.
*/
`timescale 1ns/1ps
module uxcr_idle_ins (
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   // settings and events
   input  wire logic       i_enable,
   input  wire logic [7:0] i_idle_len,
   input  wire logic       i_baud_tick,
   input  wire logic       i_char_done,
   // hold
   output logic            o_hold
);
   logic [7:0] cnt_q;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 8'h00;
      end else if (!i_enable) begin
         cnt_q <= 8'h00;
      end else if (i_char_done) begin
         cnt_q <= i_idle_len;
      end else if (i_baud_tick && cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end

   assign o_hold = (cnt_q != 8'h00);
endmodule // uxcr_idle_ins

// >>> core/uxcr_regs.sv
/*
 extended configuration register bank of one uart channel, behind the
 line-control unlock value, with baud generation, loopback, flow control
 and idle insertion hooks.
 assumes line control, modem control bit 7, divisor and fifo counts come
 from same-clock logic; serial and modem pins come from outside.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module uxcr_regs (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // register port
   input  wire logic [4:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_burst_cont,
   output logic      [7:0]  o_rdata,
   // baseline uart context
   input  wire logic [7:0]  i_line_control,
   input  wire logic        i_modem_ctl7,
   input  wire logic [15:0] i_baud_divisor,
   // fifo counters
   input  wire logic [7:0]  i_tx_fifo_count,
   input  wire logic [7:0]  i_rx_fifo_count,
   input  wire logic [7:0]  i_line_err_count,
   // transmitter and receiver
   input  wire logic        i_tx_serial,
   input  wire logic        i_tx_char_done,
   input  wire logic        i_tx_empty,
   input  wire logic        i_rx_almost_full,
   input  wire logic        i_dtr_n_sw,
   output logic             o_rx_serial,
   output logic             o_tx_allowed,
   output logic             o_baud_tick,
   // pins
   input  wire logic        i_rx_pin,
   input  wire logic        i_dsr_n_pin,
   output logic             o_tx_pin,
   output logic             o_dtr_n,
   // configuration outputs
   output logic             o_tx_empty_irq,
   output logic             o_xon_inband_en,
   output logic             o_rx_timeout_en,
   output logic             o_xtal_fb_disable,
   output logic             o_burst_en
);
   uxcr_pkg::uxcr_sfc_t sfc_q;
   uxcr_pkg::uxcr_trc_t trc_q;
   uxcr_pkg::uxcr_presc_t presc_q;
   uxcr_pkg::uxcr_trx_t trx_q;
   logic [7:0]          key_q;
   logic [7:0]          idle_time_q;
   logic [4:0]          last_addr_q;
   logic [1:0]          rx_sync_q;
   logic [1:0]          dsr_sync_q;
   logic                unlocked;
   logic                key_ok;
   logic                spec_ok;
   logic [4:0]          eff_addr;
   logic                acc_ok;
   logic                wr_ok;
   logic [7:0]          rdata_d;
   logic                idle_hold;
   logic                dsr_ok;

   // unlock conditions
   assign unlocked = (i_line_control == uxcr_pkg::LINE_CTL_UNLOCK);
   assign key_ok   = (key_q == uxcr_pkg::KEY_VALUE);
   assign spec_ok  = unlocked && sfc_q.spec_access;

   // burst continuation steps from the last address
   assign eff_addr = (sfc_q.burst && i_burst_cont) ? 5'(last_addr_q + 5'h01) : i_addr;

   // access gate per location
   always_comb begin
      unique case (eff_addr)
         uxcr_pkg::ADR_KEY: acc_ok = unlocked;
         uxcr_pkg::ADR_SFC: acc_ok = unlocked && key_ok;
         uxcr_pkg::ADR_TFL: acc_ok = spec_ok;
         uxcr_pkg::ADR_PRESC,
         uxcr_pkg::ADR_CNT,
         uxcr_pkg::ADR_IDLE,
         uxcr_pkg::ADR_TRX: acc_ok = spec_ok;
         uxcr_pkg::ADR_TRC: acc_ok = spec_ok;
         default:           acc_ok = 1'b0;
      endcase
   end

   assign wr_ok = i_wr && acc_ok;

   // burst address memory
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         last_addr_q <= 5'h00;
      end else if (i_wr || i_rd) begin
         last_addr_q <= eff_addr;
      end
   end

   // unlock key
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         key_q <= uxcr_pkg::KEY_RST;
      end else if (wr_ok && eff_addr == uxcr_pkg::ADR_KEY) begin
         key_q <= i_wdata;
      end
   end

   // special function control
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sfc_q <= uxcr_pkg::uxcr_sfc_t'(uxcr_pkg::SFC_RST);
      end else if (wr_ok && eff_addr == uxcr_pkg::ADR_SFC) begin
         sfc_q <= uxcr_pkg::uxcr_sfc_t'(i_wdata);
      end
   end

   // clock prescale
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         presc_q <= uxcr_pkg::uxcr_presc_t'(uxcr_pkg::PRESC_RST);
      end else if (wr_ok && eff_addr == uxcr_pkg::ADR_PRESC) begin
         presc_q <= uxcr_pkg::uxcr_presc_t'(i_wdata);
      end
   end

   // transmit idle time
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         idle_time_q <= uxcr_pkg::IDLE_RST;
      end else if (wr_ok && eff_addr == uxcr_pkg::ADR_IDLE) begin
         idle_time_q <= i_wdata;
      end
   end

   // tx/rx control
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         trc_q <= uxcr_pkg::uxcr_trc_t'(uxcr_pkg::TRC_RST);
      end else if (wr_ok && eff_addr == uxcr_pkg::ADR_TRC) begin
         trc_q <= uxcr_pkg::uxcr_trc_t'(i_wdata);
      end
   end

   // tx/rx control extension
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         trx_q <= uxcr_pkg::uxcr_trx_t'(uxcr_pkg::TRX_RST);
      end else if (wr_ok && eff_addr == uxcr_pkg::ADR_TRX) begin
         trx_q <= uxcr_pkg::uxcr_trx_t'({7'h00, i_wdata[0]});
      end
   end

   // read mux, hidden locations read zero
   always_comb begin
      rdata_d = 8'h00;
      if (i_rd && acc_ok) begin
         unique case (eff_addr)
            uxcr_pkg::ADR_KEY:   rdata_d = key_q;
            uxcr_pkg::ADR_SFC:   rdata_d = sfc_q;
            uxcr_pkg::ADR_PRESC: rdata_d = presc_q;
            uxcr_pkg::ADR_CNT:   rdata_d = sfc_q.cnt_sel ? i_line_err_count : i_rx_fifo_count;
            uxcr_pkg::ADR_TFL:   rdata_d = i_tx_fifo_count;
            uxcr_pkg::ADR_IDLE:  rdata_d = idle_time_q;
            uxcr_pkg::ADR_TRC:   rdata_d = trc_q;
            uxcr_pkg::ADR_TRX:   rdata_d = trx_q;
            default:             rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rdata_d;
      end
   end

   // pin synchronisers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_sync_q  <= 2'b11;
         dsr_sync_q <= 2'b11;
      end else begin
         rx_sync_q  <= {rx_sync_q[0], i_rx_pin};
         dsr_sync_q <= {dsr_sync_q[0], i_dsr_n_pin};
      end
   end

   assign o_rx_serial = rx_sync_q[1];

   // serial output and flow control pins
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tx_pin <= 1'b1;
         o_dtr_n  <= 1'b1;
      end else begin
         o_tx_pin <= sfc_q.loopback ? rx_sync_q[1] : i_tx_serial;
         o_dtr_n  <= sfc_q.auto_dsr_dtr ? i_rx_almost_full : i_dtr_n_sw;
      end
   end

   // transmit gating
   assign dsr_ok       = !sfc_q.auto_dsr_dtr || !dsr_sync_q[1];
   assign o_tx_allowed = sfc_q.force_tx || (dsr_ok && !idle_hold);

   // configuration outputs
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tx_empty_irq <= 1'b0;
      end else begin
         o_tx_empty_irq <= trc_q.tx_empty_ie && i_tx_empty;
      end
   end

   assign o_xon_inband_en   = trc_q.xon_inband;
   assign o_rx_timeout_en   = trc_q.rx_timeout_en;
   assign o_xtal_fb_disable = sfc_q.xtal_fb_dis;
   assign o_burst_en        = sfc_q.burst;

   // baud rate generator
   uxcr_baud_gen u_baud (
      .i_ref_clk    (i_ref_clk),
      .i_rst        (i_rst),
      .i_divisor    (i_baud_divisor),
      .i_modem7     (i_modem_ctl7),
      .i_m_factor   (presc_q.m_factor),
      .i_n_factor   (presc_q.n_factor),
      .i_sample_clk (trc_q.sample_clk),
      .o_baud_tick  (o_baud_tick)
   );

   // idle insertion
   uxcr_idle_ins u_idle (
      .i_ref_clk   (i_ref_clk),
      .i_rst       (i_rst),
      .i_enable    (trx_q.idle_ins_en),
      .i_idle_len  (idle_time_q),
      .i_baud_tick (o_baud_tick),
      .i_char_done (i_tx_char_done),
      .o_hold      (idle_hold)
   );

   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_tfl_read_live: assert property (
      (i_rd && eff_addr == uxcr_pkg::ADR_TFL && spec_ok) |=> o_rdata == $past(i_tx_fifo_count))
      else $error("tx fifo level read wrong");

   a_tfl_hidden_zero: assert property (
      (i_rd && eff_addr == uxcr_pkg::ADR_TFL && !sfc_q.spec_access) |=> o_rdata == 8'h00)
      else $error("tx fifo level visible while hidden");

   a_sfc_key_lock: assert property (
      (i_wr && eff_addr == uxcr_pkg::ADR_SFC && !(unlocked && key_ok)) |=> $stable(sfc_q))
      else $error("sfc written while locked");

   a_sfc_key_write: assert property (
      (i_wr && eff_addr == uxcr_pkg::ADR_SFC && unlocked && key_ok) |=> sfc_q == $past(i_wdata))
      else $error("sfc write lost");

   a_trc_hidden_hold: assert property (
      (i_wr && eff_addr == uxcr_pkg::ADR_TRC && !spec_ok) |=> $stable(trc_q))
      else $error("tx/rx control written while hidden");

   a_idle_hidden_hold: assert property (
      (i_wr && eff_addr == uxcr_pkg::ADR_IDLE && !spec_ok) |=> $stable(idle_time_q))
      else $error("idle time written while hidden");

   a_cnt_select_err: assert property (
      (i_rd && eff_addr == uxcr_pkg::ADR_CNT && spec_ok && sfc_q.cnt_sel)
      |=> o_rdata == $past(i_line_err_count))
      else $error("error counter not selected");

   a_cnt_select_rx: assert property (
      (i_rd && eff_addr == uxcr_pkg::ADR_CNT && spec_ok && !sfc_q.cnt_sel)
      |=> o_rdata == $past(i_rx_fifo_count))
      else $error("rx counter not selected");

   a_loop_route: assert property (
      sfc_q.loopback ##1 sfc_q.loopback |-> o_tx_pin == $past(rx_sync_q[1]))
      else $error("loopback not routed");

   a_force_send: assert property (
      sfc_q.force_tx |-> o_tx_allowed)
      else $error("forced transmit blocked");

   a_idle_hold_gate: assert property (
      (idle_hold && !sfc_q.force_tx) |-> !o_tx_allowed)
      else $error("transmit not held in idle time");

   a_dsr_gate: assert property (
      (sfc_q.auto_dsr_dtr && dsr_sync_q[1] && !sfc_q.force_tx) |-> !o_tx_allowed)
      else $error("dsr flow control ignored");

   a_burst_step: assert property (
      (sfc_q.burst && i_burst_cont && (i_rd || i_wr)) |=> last_addr_q == 5'($past(last_addr_q) + 5'h01))
      else $error("burst address did not step");

   c_unlock_seq:  cover property (wr_ok && eff_addr == uxcr_pkg::ADR_KEY ##[1:8] wr_ok && eff_addr == uxcr_pkg::ADR_SFC);
   c_tfl_read:    cover property (i_rd && eff_addr == uxcr_pkg::ADR_TFL && spec_ok);
   c_idle_hold:   cover property (idle_hold ##1 !idle_hold);
   c_burst_write: cover property (wr_ok && sfc_q.burst && i_burst_cont);
endmodule // uxcr_regs

// >>> tb/testbench.sv
/*
 self-checking bench for the extended uart configuration register bank.
 assumes the package and core files are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
   logic        i_ref_clk        = 1'b0;
   logic        i_rst            = 1'b1;
   logic [4:0]  i_addr           = 5'h00;
   logic [7:0]  i_wdata          = 8'h00;
   logic        i_wr             = 1'b0;
   logic        i_rd             = 1'b0;
   logic        i_burst_cont     = 1'b0;
   logic [7:0]  i_line_control   = 8'h00;
   logic        i_modem_ctl7     = 1'b0;
   logic [15:0] i_baud_divisor   = 16'h0002;
   logic [7:0]  i_tx_fifo_count  = 8'h00;
   logic [7:0]  i_rx_fifo_count  = 8'h00;
   logic [7:0]  i_line_err_count = 8'h00;
   logic        i_tx_serial      = 1'b1;
   logic        i_tx_char_done   = 1'b0;
   logic        i_tx_empty       = 1'b0;
   logic        i_rx_almost_full = 1'b0;
   logic        i_dtr_n_sw       = 1'b1;
   logic        i_rx_pin         = 1'b1;
   logic        i_dsr_n_pin      = 1'b0;
   logic [7:0]  o_rdata;
   logic        o_rx_serial;
   logic        o_tx_allowed;
   logic        o_baud_tick;
   logic        o_tx_pin;
   logic        o_dtr_n;
   logic        o_tx_empty_irq;
   logic        o_xon_inband_en;
   logic        o_rx_timeout_en;
   logic        o_xtal_fb_disable;
   logic        o_burst_en;
   int          mismatches       = 0;
   int          tests_run        = 0;

   always #5 i_ref_clk = ~i_ref_clk;

   uxcr_regs dut (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_burst_cont(i_burst_cont), .o_rdata(o_rdata), .i_line_control(i_line_control),
      .i_modem_ctl7(i_modem_ctl7), .i_baud_divisor(i_baud_divisor), .i_tx_fifo_count(i_tx_fifo_count),
      .i_rx_fifo_count(i_rx_fifo_count), .i_line_err_count(i_line_err_count), .i_tx_serial(i_tx_serial),
      .i_tx_char_done(i_tx_char_done), .i_tx_empty(i_tx_empty), .i_rx_almost_full(i_rx_almost_full),
      .i_dtr_n_sw(i_dtr_n_sw), .o_rx_serial(o_rx_serial), .o_tx_allowed(o_tx_allowed),
      .o_baud_tick(o_baud_tick), .i_rx_pin(i_rx_pin), .i_dsr_n_pin(i_dsr_n_pin), .o_tx_pin(o_tx_pin),
      .o_dtr_n(o_dtr_n), .o_tx_empty_irq(o_tx_empty_irq), .o_xon_inband_en(o_xon_inband_en),
      .o_rx_timeout_en(o_rx_timeout_en), .o_xtal_fb_disable(o_xtal_fb_disable), .o_burst_en(o_burst_en));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_ref_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic c, output logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr       <= a;
      i_burst_cont <= c;
      i_rd         <= 1'b1;
      @(posedge i_ref_clk);
      i_rd         <= 1'b0;
      i_burst_cont <= 1'b0;
      @(negedge i_ref_clk);
      d = o_rdata;
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, 1'b0, d);
      chk({8'h00, d}, {8'h00, exp});
   endtask

   task automatic set_line_ctl(input logic [7:0] v);
      @(posedge i_ref_clk);
      i_line_control <= v;
   endtask

   task automatic tick_gap(output logic [15:0] n);
      int k;
      k = 0;
      @(negedge i_ref_clk);
      while (o_baud_tick !== 1'b1 && k < 1000) begin
         @(negedge i_ref_clk);
         k++;
      end
      n = 16'h0000;
      @(negedge i_ref_clk);
      while (o_baud_tick !== 1'b1 && n < 16'd1000) begin
         @(negedge i_ref_clk);
         n++;
      end
      n++;
   endtask

   task automatic t_unlock;
      wr(uxcr_pkg::ADR_TRC, 8'hff);
      rdchk(uxcr_pkg::ADR_SFC, 8'h00);
      set_line_ctl(uxcr_pkg::LINE_CTL_UNLOCK);
      wr(uxcr_pkg::ADR_SFC, 8'h04);
      rdchk(uxcr_pkg::ADR_TFL, 8'h00);
      wr(uxcr_pkg::ADR_KEY, uxcr_pkg::KEY_VALUE);
      rdchk(uxcr_pkg::ADR_SFC, uxcr_pkg::SFC_RST);
      wr(uxcr_pkg::ADR_SFC, 8'h04);
      rdchk(uxcr_pkg::ADR_SFC, 8'h04);
      rdchk(uxcr_pkg::ADR_TRC, uxcr_pkg::TRC_RST);
      rdchk(uxcr_pkg::ADR_IDLE, uxcr_pkg::IDLE_RST);
      rdchk(uxcr_pkg::ADR_PRESC, uxcr_pkg::PRESC_RST);
      chk({15'h0, o_xon_inband_en}, 16'h0001);
      $display("test unlock done");
   endtask

   task automatic t_counters;
      @(posedge i_ref_clk);
      i_tx_fifo_count  <= 8'h2c;
      i_rx_fifo_count  <= 8'h11;
      i_line_err_count <= 8'h07;
      rdchk(uxcr_pkg::ADR_TFL, 8'h2c);
      wr(uxcr_pkg::ADR_TFL, 8'hff);
      rdchk(uxcr_pkg::ADR_TFL, 8'h2c);
      rdchk(uxcr_pkg::ADR_CNT, 8'h11);
      wr(uxcr_pkg::ADR_SFC, 8'h44);
      rdchk(uxcr_pkg::ADR_CNT, 8'h07);
      $display("test counters done");
   endtask

   task automatic t_hidden;
      wr(uxcr_pkg::ADR_SFC, 8'h00);
      rdchk(uxcr_pkg::ADR_TFL, 8'h00);
      wr(uxcr_pkg::ADR_IDLE, 8'h33);
      rdchk(uxcr_pkg::ADR_TRC, 8'h00);
      wr(uxcr_pkg::ADR_SFC, 8'h04);
      rdchk(uxcr_pkg::ADR_IDLE, 8'h00);
      wr(uxcr_pkg::ADR_IDLE, 8'ha5);
      rdchk(uxcr_pkg::ADR_IDLE, 8'ha5);
      set_line_ctl(8'h03);
      rdchk(uxcr_pkg::ADR_IDLE, 8'h00);
      wr(uxcr_pkg::ADR_TRC, 8'h00);
      set_line_ctl(uxcr_pkg::LINE_CTL_UNLOCK);
      rdchk(uxcr_pkg::ADR_TRC, uxcr_pkg::TRC_RST);
      $display("test hidden done");
   endtask

   task automatic t_control;
      wr(uxcr_pkg::ADR_TRC, 8'h01);
      @(posedge i_ref_clk);
      i_tx_empty <= 1'b1;
      cyc(3);
      chk({15'h0, o_xon_inband_en}, 16'h0000);
      chk({15'h0, o_rx_timeout_en}, 16'h0001);
      chk({15'h0, o_tx_empty_irq}, 16'h0000);
      wr(uxcr_pkg::ADR_TRC, 8'h06);
      cyc(2);
      chk({15'h0, o_tx_empty_irq}, 16'h0001);
      chk({15'h0, o_rx_timeout_en}, 16'h0000);
      $display("test control done");
   endtask

   task automatic t_burst;
      logic [7:0] d;
      wr(uxcr_pkg::ADR_SFC, 8'h94);
      cyc(1);
      chk({14'h0, o_burst_en, o_xtal_fb_disable}, 16'h0003);
      rd(uxcr_pkg::ADR_IDLE, 1'b0, d);
      rd(uxcr_pkg::ADR_PRESC, 1'b1, d);
      chk({8'h00, d}, {8'h00, uxcr_pkg::TRC_RST});
      wr(uxcr_pkg::ADR_SFC, 8'h04);
      $display("test burst done");
   endtask

   task automatic t_loop;
      wr(uxcr_pkg::ADR_SFC, 8'h0c);
      @(posedge i_ref_clk);
      i_rx_pin    <= 1'b0;
      i_tx_serial <= 1'b1;
      cyc(5);
      chk({14'h0, o_tx_pin, o_rx_serial}, 16'h0000);
      @(posedge i_ref_clk);
      i_rx_pin    <= 1'b1;
      i_tx_serial <= 1'b0;
      cyc(5);
      chk({15'h0, o_tx_pin}, 16'h0001);
      wr(uxcr_pkg::ADR_SFC, 8'h04);
      cyc(3);
      chk({15'h0, o_tx_pin}, 16'h0000);
      $display("test loopback done");
   endtask

   task automatic t_flow;
      wr(uxcr_pkg::ADR_SFC, 8'h06);
      @(posedge i_ref_clk);
      i_dsr_n_pin <= 1'b1;
      cyc(5);
      chk({14'h0, o_tx_allowed, o_dtr_n}, 16'h0000);
      wr(uxcr_pkg::ADR_SFC, 8'h07);
      cyc(1);
      chk({15'h0, o_tx_allowed}, 16'h0001);
      wr(uxcr_pkg::ADR_SFC, 8'h04);
      cyc(2);
      chk({14'h0, o_tx_allowed, o_dtr_n}, 16'h0003);
      @(posedge i_ref_clk);
      i_dsr_n_pin <= 1'b0;
      $display("test flow done");
   endtask

   task automatic t_baud;
      logic [15:0] n;
      tick_gap(n);
      tick_gap(n);
      chk(n, 16'd32);
      wr(uxcr_pkg::ADR_PRESC, 8'h14);
      tick_gap(n);
      tick_gap(n);
      chk(n, 16'd40);
      wr(uxcr_pkg::ADR_TRC, 8'h26);
      @(posedge i_ref_clk);
      i_modem_ctl7 <= 1'b1;
      tick_gap(n);
      tick_gap(n);
      chk(n, 16'd128);
      @(posedge i_ref_clk);
      i_modem_ctl7 <= 1'b0;
      wr(uxcr_pkg::ADR_TRC, 8'h06);
      $display("test baud done");
   endtask

   task automatic t_idle;
      int k;
      wr(uxcr_pkg::ADR_IDLE, 8'h03);
      wr(uxcr_pkg::ADR_TRX, 8'h01);
      @(posedge i_ref_clk);
      i_tx_char_done <= 1'b1;
      @(posedge i_ref_clk);
      i_tx_char_done <= 1'b0;
      @(negedge i_ref_clk);
      chk({15'h0, o_tx_allowed}, 16'h0000);
      k = 0;
      while (o_tx_allowed !== 1'b1 && k < 400) begin
         @(negedge i_ref_clk);
         k++;
      end
      chk({15'h0, (k >= 80 && k <= 130)}, 16'h0001);
      $display("test idle done");
   endtask

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      t_unlock();
      t_counters();
      t_hidden();
      t_control();
      t_burst();
      t_loop();
      t_flow();
      t_baud();
      t_idle();
      close_out();
   end

   initial begin
      #200us;
      mismatches++;
      close_out();
   end
endmodule // testbench
